/* File: hdl/dcelb_bank.sv */
// data cache error-reporting register bank with model-specific register access
`timescale 1ns/1ps

module dcelb_bank (
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    global_data_cache_gate_in,
  input  wire logic                    err_valid_in,
  input  wire dcelb_pkg::dcelb_err_t   err_in,
  input  wire dcelb_pkg::dcelb_msr_req_t msr_req_in,
  output logic [63:0]                  msr_rdata_out,
  output logic                         msr_hit_out,
  output logic                         mce_out
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [63:0] enables_ff;
  logic [63:0] nxt_enables;
  logic [63:0] block_ff;
  logic [63:0] nxt_block;
  logic [63:0] record_ff;
  logic [63:0] nxt_record;
  logic [63:0] location_ff;
  logic [63:0] nxt_location;
  logic [63:0] rdata_ff;
  logic [63:0] nxt_rdata;
  logic        hit_ff;
  logic        nxt_hit;
  logic        mce_ff;
  logic        nxt_mce;

  function automatic logic sel(input logic [31:0] idx, input logic [31:0] want);
    sel = (idx == want);
  endfunction

  // ---------------------------------------------------------------
  // class decode
  // ---------------------------------------------------------------
  // an out-of-range class index matches no enable bit and is logged as disabled
  logic [dcelb_pkg::NUM_CLASSES-1:0] cls_hit;

  for (genvar g = 0; g < dcelb_pkg::NUM_CLASSES; g++)
  begin : g_cls
    assign cls_hit[g] = (err_in.err_class == 3'(g)) && enables_ff[g];
  end

  // ---------------------------------------------------------------
  // error capture
  // ---------------------------------------------------------------
  logic        cls_en;
  logic        take;
  logic        new_uc;
  logic        old_uc;
  logic        old_en;
  logic [63:0] err_rec;
  logic [63:0] loc_merge;

  always_comb
  begin
    cls_en = |cls_hit;
    new_uc = err_in.not_corrected;
    old_uc = record_ff[dcelb_pkg::REC_UC_BIT];
    old_en = record_ff[dcelb_pkg::REC_EN_BIT];
    // without a valid record any error is taken; otherwise priority decides
    if (!record_ff[dcelb_pkg::REC_VALID_BIT])
      take = 1'b1;
    else if (old_uc)
      take = 1'b0;
    else if (new_uc)
      take = 1'b1;
    else
      take = cls_en && !old_en;
  end

  // ---------------------------------------------------------------
  // record word for the incoming error
  // ---------------------------------------------------------------
  always_comb
  begin
    err_rec = 64'h0;
    err_rec[dcelb_pkg::REC_VALID_BIT] = 1'b1;
    err_rec[dcelb_pkg::REC_UC_BIT]    = err_in.not_corrected;
    err_rec[dcelb_pkg::REC_EN_BIT]    = cls_en;
    err_rec[dcelb_pkg::REC_EXTRA_INFO_PRESENT_BIT] = 1'b0;
    err_rec[dcelb_pkg::REC_FAULT_LOCATION_PRESENT_BIT] = err_in.fault_location_present;
    err_rec[dcelb_pkg::REC_PCC_BIT]   = err_in.context_corrupt_flag;
    if (err_in.correctable_ecc_flag || err_in.uncorrectable_ecc_flag)
      err_rec[dcelb_pkg::REC_SYND_LSB +: 8] = err_in.syndrome;
    err_rec[dcelb_pkg::REC_CORRECTABLE_ECC_FLAG_BIT]  = err_in.correctable_ecc_flag;
    err_rec[dcelb_pkg::REC_UNCORRECTABLE_ECC_FLAG_BIT]  = err_in.uncorrectable_ecc_flag;
    err_rec[dcelb_pkg::REC_SCRUB_BIT] = err_in.scrub;
    err_rec[dcelb_pkg::REC_SUBCL_LSB +: 4] = err_in.fault_subclass_field;
    err_rec[dcelb_pkg::REC_CODE_LSB +: 16] = err_in.err_code;
  end

  // ---------------------------------------------------------------
  // address merge
  // ---------------------------------------------------------------
  always_comb
  begin
    // bits outside the class-defined range keep their old content
    loc_merge = {16'h0, (location_ff[dcelb_pkg::ADDR_W-1:0] & ~err_in.valid_bits)
                        | (err_in.address & err_in.valid_bits)};
  end

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic wr_enables;
  logic wr_block;
  logic wr_record;
  logic wr_location;
  logic capture;

  always_comb
  begin
    wr_enables  = 1'b0;
    wr_block    = 1'b0;
    wr_record   = 1'b0;
    wr_location = 1'b0;
    // writes to the extra info index and to unmapped indices fall through
    if (msr_req_in.wr)
    begin
      if (sel(msr_req_in.index, dcelb_pkg::ENABLES_IDX))
        wr_enables = 1'b1;
      else if (sel(msr_req_in.index, dcelb_pkg::WRITE_BLOCK_IDX))
        wr_block = 1'b1;
      else if (sel(msr_req_in.index, dcelb_pkg::RECORD_IDX))
        wr_record = 1'b1;
      else if (sel(msr_req_in.index, dcelb_pkg::LOCATION_IDX))
        wr_location = 1'b1;
    end
  end

  // the gate is sampled with the pulse; an error seen with the gate clear is lost
  assign capture = err_valid_in && global_data_cache_gate_in;

  // ---------------------------------------------------------------
  // enables and write block
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_enables = enables_ff;
    nxt_block   = block_ff;
    // the block acts at write time only; setting it later leaves set enables alone
    if (wr_enables)
      nxt_enables = msr_req_in.wdata & ~block_ff & dcelb_pkg::ENABLES_MASK;
    if (wr_block)
      nxt_block = msr_req_in.wdata;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      enables_ff <= dcelb_pkg::ENABLES_RESET;
      block_ff   <= dcelb_pkg::BLOCK_RESET;
    end
    else
    begin
      enables_ff <= nxt_enables;
      block_ff   <= nxt_block;
    end
  end

  // ---------------------------------------------------------------
  // status record and error address
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_record   = record_ff;
    nxt_location = location_ff;
    if (wr_record)
      nxt_record = msr_req_in.wdata & dcelb_pkg::RECORD_MASK;
    if (wr_location)
      nxt_location = msr_req_in.wdata & dcelb_pkg::LOCATION_MASK;
    // an error beats a software write landing in the same cycle, unless a valid record keeps it out; then the write lands with overflow set
    if (capture)
    begin
      if (record_ff[dcelb_pkg::REC_VALID_BIT])
      begin
        if (take)
        begin
          nxt_record   = err_rec;
          nxt_location = loc_merge;
        end
        nxt_record[dcelb_pkg::REC_OVER_BIT] = 1'b1;
      end
      else
      begin
        nxt_record   = err_rec;
        nxt_location = loc_merge;
      end
    end
    // the extra info register never holds anything, so software cannot set its flag
    nxt_record[dcelb_pkg::REC_EXTRA_INFO_PRESENT_BIT] = 1'b0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      record_ff   <= dcelb_pkg::RECORD_RESET;
      location_ff <= dcelb_pkg::LOCATION_RESET;
    end
    else
    begin
      record_ff   <= nxt_record;
      location_ff <= nxt_location;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = rdata_ff;
    nxt_hit   = 1'b0;
    // a read beside a write in one cycle returns the value from before the write
    if (msr_req_in.rd)
    begin
      nxt_hit = 1'b1;
      if (sel(msr_req_in.index, dcelb_pkg::ENABLES_IDX))
        nxt_rdata = enables_ff;
      else if (sel(msr_req_in.index, dcelb_pkg::WRITE_BLOCK_IDX))
        nxt_rdata = block_ff;
      else if (sel(msr_req_in.index, dcelb_pkg::RECORD_IDX))
        nxt_rdata = record_ff;
      else if (sel(msr_req_in.index, dcelb_pkg::LOCATION_IDX))
        nxt_rdata = location_ff;
      else if (sel(msr_req_in.index, dcelb_pkg::EXTRA_IDX))
        nxt_rdata = 64'h0;
      else
      begin
        nxt_rdata = 64'h0;
        nxt_hit   = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_ff <= 64'h0;
      hit_ff   <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      hit_ff   <= nxt_hit;
    end
  end

  // ---------------------------------------------------------------
  // exception
  // ---------------------------------------------------------------
  always_comb
  begin
    // pulses for every enabled error, even one that only sets the overflow flag
    nxt_mce = capture && cls_en;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mce_ff <= 1'b0;
    end
    else
    begin
      mce_ff <= nxt_mce;
    end
  end

  assign msr_rdata_out = rdata_ff;
  assign msr_hit_out   = hit_ff;
  assign mce_out       = mce_ff;

endmodule

/* File: hdl/dcelb_pkg.sv */
// package: register indices, field positions and carrier types of the data cache error bank
package dcelb_pkg;

  // register indices (model-specific register numbers)
  localparam logic [31:0] ENABLES_IDX     = 32'h0000_0400;
  localparam logic [31:0] RECORD_IDX      = 32'h0000_0401;
  localparam logic [31:0] LOCATION_IDX    = 32'h0000_0402;
  localparam logic [31:0] EXTRA_IDX       = 32'h0000_0403;
  localparam logic [31:0] WRITE_BLOCK_IDX = 32'hc001_0044;

  // enable register layout
  localparam int          NUM_CLASSES   = 7;
  localparam logic [63:0] ENABLES_RESET = 64'h0;
  localparam logic [63:0] ENABLES_MASK  = 64'h0000_0000_0000_007f;
  localparam logic [63:0] BLOCK_RESET   = 64'h0;

  // record field positions
  localparam int REC_VALID_BIT   = 63;
  localparam int REC_OVER_BIT    = 62;
  localparam int REC_UC_BIT      = 61;
  localparam int REC_EN_BIT      = 60;
  localparam int REC_EXTRA_INFO_PRESENT_BIT   = 59;
  localparam int REC_FAULT_LOCATION_PRESENT_BIT   = 58;
  localparam int REC_PCC_BIT     = 57;
  localparam int REC_SYND_LSB    = 47;
  localparam int REC_CORRECTABLE_ECC_FLAG_BIT    = 46;
  localparam int REC_UNCORRECTABLE_ECC_FLAG_BIT    = 45;
  localparam int REC_SCRUB_BIT   = 40;
  localparam int REC_SUBCL_LSB   = 16;
  localparam int REC_CODE_LSB    = 0;
  localparam logic [63:0] RECORD_MASK  = 64'hfe7f_e100_000f_ffff;
  localparam logic [63:0] RECORD_RESET = 64'h0;

  // address register layout
  localparam int          ADDR_W         = 48;
  localparam logic [63:0] LOCATION_MASK  = 64'h0000_ffff_ffff_ffff;
  localparam logic [63:0] LOCATION_RESET = 64'h0;

  // one detected error from the cache or TLB checkers
  typedef struct packed {
    logic [2:0]        err_class;     // index of the enable bit 0..6
    logic              not_corrected;
    logic              context_corrupt_flag;
    logic              fault_location_present;
    logic              correctable_ecc_flag;
    logic              uncorrectable_ecc_flag;
    logic              scrub;
    logic [7:0]        syndrome;
    logic [3:0]        fault_subclass_field;
    logic [15:0]       err_code;
    logic [ADDR_W-1:0] valid_bits;    // which address bits this error class defines
    logic [ADDR_W-1:0] address;       // linear or physical, chosen by the detector
  } dcelb_err_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] index;
    logic [63:0] wdata;
  } dcelb_msr_req_t;

endpackage

/* File: test/dcelb_chk.sv */
// port assertions of the data cache error bank
`timescale 1ns/1ps
module dcelb_chk (
  input wire logic                      clk_sys_in,
  input wire logic                      rst_n_in,
  input wire logic                      global_data_cache_gate_in,
  input wire logic                      err_valid_in,
  input wire dcelb_pkg::dcelb_err_t     err_in,
  input wire dcelb_pkg::dcelb_msr_req_t msr_req_in,
  input wire logic [63:0]               msr_rdata_out,
  input wire logic                      msr_hit_out,
  input wire logic                      mce_out
);
  logic rd_en;
  logic rd_rec;
  logic mapped;
  assign rd_en  = msr_req_in.rd && msr_req_in.index == dcelb_pkg::ENABLES_IDX;
  assign rd_rec = msr_req_in.rd && msr_req_in.index == dcelb_pkg::RECORD_IDX;
  assign mapped = msr_req_in.index inside {dcelb_pkg::ENABLES_IDX, dcelb_pkg::RECORD_IDX,
    dcelb_pkg::LOCATION_IDX, dcelb_pkg::EXTRA_IDX, dcelb_pkg::WRITE_BLOCK_IDX};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  mce_cause_a: assert property (mce_out |-> $past(err_valid_in && global_data_cache_gate_in))
    else $error("exception without a gated error");
  gate_off_a: assert property (err_valid_in && !global_data_cache_gate_in |=> !mce_out)
    else $error("exception with gate clear");
  unmapped_a: assert property (msr_req_in.rd && !mapped |=> !msr_hit_out && msr_rdata_out == '0)
    else $error("unmapped read answered");
  extra_zero_a: assert property (msr_req_in.rd && msr_req_in.index == dcelb_pkg::EXTRA_IDX
    |=> msr_hit_out && msr_rdata_out == '0) else $error("extra info not zero");
  loc_width_a: assert property (msr_req_in.rd && msr_req_in.index == dcelb_pkg::LOCATION_IDX
    |=> msr_rdata_out[63:48] == 16'h0) else $error("address upper bits set");
  en_resv_a: assert property (rd_en |=> msr_rdata_out[63:7] == '0)
    else $error("enable reserved bits set");
  rec_resv_a: assert property (rd_rec |=> (msr_rdata_out & ~dcelb_pkg::RECORD_MASK) == '0
    && !msr_rdata_out[59]) else $error("record reserved bits set");
  enable_sub_a: assert property (msr_req_in.wr && msr_req_in.index == dcelb_pkg::ENABLES_IDX
    ##1 !msr_req_in.wr ##1 rd_en && !msr_req_in.wr
    |=> (msr_rdata_out & ~$past(msr_req_in.wdata, 3)) == '0)
    else $error("enable bit set beyond written value");
endmodule
bind dcelb_bank dcelb_chk u_chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .global_data_cache_gate_in(global_data_cache_gate_in), .err_valid_in(err_valid_in),
  .err_in(err_in), .msr_req_in(msr_req_in), .msr_rdata_out(msr_rdata_out),
  .msr_hit_out(msr_hit_out), .mce_out(mce_out));

/* File: test/dcelb_det.sv */
// error detector model feeding the bank
`timescale 1ns/1ps
module dcelb_det (
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  fire_in,
  input  wire dcelb_pkg::dcelb_err_t desc_in,
  output logic                       err_valid_out,
  output dcelb_pkg::dcelb_err_t      err_out
);
  // outside a report the descriptor shows junk, so the bank must qualify with valid
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      err_valid_out <= 1'b0;
      err_out       <= '0;
    end
    else
    begin
      err_valid_out <= fire_in;
      err_out       <= fire_in ? desc_in : ~desc_in;
    end
endmodule

/* File: test/dcelb_bank_tb_top.sv */
// self-checking bench of the data cache error bank
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module dcelb_bank_tb_top;
  logic                      clk_sys_in = 1'b0;
  logic                      rst_n_in   = 1'b0;
  logic                      gate       = 1'b0;
  logic                      fire       = 1'b0;
  dcelb_pkg::dcelb_err_t     desc       = '0;
  dcelb_pkg::dcelb_err_t     err;
  dcelb_pkg::dcelb_msr_req_t req        = '0;
  logic                      err_valid;
  logic [63:0]               rdata;
  logic                      hit;
  logic                      mce;
  int                        error_cnt  = 0;
  int                        checks     = 0;
  int                        mce_n      = 0;
  int                        cycles     = 0;
  // the extra info flag can never be set, not even by software
  localparam logic [63:0] REC_WRITABLE = dcelb_pkg::RECORD_MASK & 64'hf7ff_ffff_ffff_ffff;
  logic [31:0]               idx_list [5] = '{dcelb_pkg::ENABLES_IDX, dcelb_pkg::RECORD_IDX,
    dcelb_pkg::LOCATION_IDX, dcelb_pkg::EXTRA_IDX, dcelb_pkg::WRITE_BLOCK_IDX};
  dcelb_det u_det (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .fire_in(fire),
    .desc_in(desc), .err_valid_out(err_valid), .err_out(err));
  dcelb_bank u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .global_data_cache_gate_in(gate), .err_valid_in(err_valid), .err_in(err),
    .msr_req_in(req), .msr_rdata_out(rdata), .msr_hit_out(hit), .mce_out(mce));
  initial forever #2 clk_sys_in = ~clk_sys_in;
  // the whole run needs well under a thousand cycles
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (mce === 1'b1) mce_n++;
    if (cycles == 5000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("mismatches %0d of %0d comparisons", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [31:0] idx, input logic [63:0] d);
    @(posedge clk_sys_in);
    req <= '{wr: 1'b1, rd: 1'b0, index: idx, wdata: d};
    @(posedge clk_sys_in);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] idx, input logic [63:0] exp, input logic h);
    @(posedge clk_sys_in);
    req <= '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 64'h0};
    @(posedge clk_sys_in);
    req.rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
    `CHK(hit, h)
  endtask
  task automatic inject(input logic [2:0] c, input logic uc);
    @(posedge clk_sys_in);
    fire <= 1'b1;
    desc <= '{err_class: c, not_corrected: uc, context_corrupt_flag: uc,
      fault_location_present: 1'b1, correctable_ecc_flag: !uc, uncorrectable_ecc_flag: uc,
      scrub: 1'b1, syndrome: 8'ha5, fault_subclass_field: 4'h3, err_code: {13'h0, c},
      valid_bits: 48'h00ff_ffff_fff8, address: 48'hffff_ffff_ffff};
    @(posedge clk_sys_in);
    fire <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask
  function automatic logic [63:0] rec(input logic [2:0] c, input logic ov, input logic uc,
    input logic en);
    rec = {1'b1, ov, uc, en, 2'b01, uc, 2'b0, 8'ha5, !uc, uc, 4'h0, 1'b1, 24'h3, 13'h0, c};
  endfunction
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    foreach (idx_list[i]) rd(idx_list[i], 64'h0, 1'b1);
    rd(32'h0000_0404, 64'h0, 1'b0);
    wr(dcelb_pkg::ENABLES_IDX, '1);
    rd(dcelb_pkg::ENABLES_IDX, 64'h7f, 1'b1);
    wr(dcelb_pkg::WRITE_BLOCK_IDX, 64'h2a);
    wr(dcelb_pkg::ENABLES_IDX, '1);
    rd(dcelb_pkg::ENABLES_IDX, 64'h55, 1'b1);
    wr(dcelb_pkg::ENABLES_IDX, 64'h0f);
    rd(dcelb_pkg::ENABLES_IDX, 64'h05, 1'b1);
    wr(dcelb_pkg::ENABLES_IDX, '1);
    wr(dcelb_pkg::EXTRA_IDX, '1);
    rd(dcelb_pkg::EXTRA_IDX, 64'h0, 1'b1);
    inject(3'h0, 1'b0);
    rd(dcelb_pkg::RECORD_IDX, 64'h0, 1'b1);
    `CHK(mce_n, 0)
    @(posedge clk_sys_in);
    gate <= 1'b1;
    // classes alternate enabled and blocked under the 0x55 pattern
    for (int c = 0; c < 7; c++)
    begin
      wr(dcelb_pkg::RECORD_IDX, 64'h0);
      inject(c[2:0], 1'b0);
      rd(dcelb_pkg::RECORD_IDX, rec(c[2:0], 1'b0, 1'b0, !c[0]), 1'b1);
      `CHK(mce_n, c / 2 + 1)
    end
    rd(dcelb_pkg::LOCATION_IDX, 64'h0000_00ff_ffff_fff8, 1'b1);
    wr(dcelb_pkg::RECORD_IDX, 64'h0);
    inject(3'h1, 1'b0);
    inject(3'h0, 1'b0);
    rd(dcelb_pkg::RECORD_IDX, rec(3'h0, 1'b1, 1'b0, 1'b1), 1'b1);
    inject(3'h1, 1'b1);
    rd(dcelb_pkg::RECORD_IDX, rec(3'h1, 1'b1, 1'b1, 1'b0), 1'b1);
    inject(3'h2, 1'b0);
    rd(dcelb_pkg::RECORD_IDX, rec(3'h1, 1'b1, 1'b1, 1'b0), 1'b1);
    `CHK(mce_n, 6)
    wr(dcelb_pkg::RECORD_IDX, '1);
    rd(dcelb_pkg::RECORD_IDX, REC_WRITABLE, 1'b1);
    wr(dcelb_pkg::LOCATION_IDX, '1);
    rd(dcelb_pkg::LOCATION_IDX, dcelb_pkg::LOCATION_MASK, 1'b1);
    end_of_test();
  end
endmodule
